// File: rmsc_consts.vh
// Shared constants for the remote monitor and speed control block.
`ifndef RMSC_CONSTS_VH
`define RMSC_CONSTS_VH
// Monitor source codes.
`define MON_INPUT 2'h0
`define MON_SYNC 2'h1
`define MON_PLAY 2'h2
// Speed reference selector codes.
`define SPD_FIX 2'h0
`define SPD_EXT 2'h1
`define SPD_VARI 2'h2
// Pitch in hundredths of a percent, signed.
`define PITCH_MAX 14'h1388
`define PITCH_MIN 14'h2C78
`define PITCH_FINE 14'h0001
`define PITCH_COARSE 14'h0064
// Knob detents closer than this many nanoseconds count as fast rotation.
`define FAST_GAP_NS 20000000
`define CLK_NS 4
// Window for a second quick press of an all button.
`define DOUBLE_NS 400000000
`endif

// File: pitch_knob.v
// Velocity sensitive pitch accumulator driven by knob detent pulses.
`timescale 1ns/1ps
`include "rmsc_consts.vh"
module pitch_knob #(
   parameter FAST_CYCLES = `FAST_GAP_NS / `CLK_NS
) (
   input wire clock,
   input wire srst,
   input wire step_up,
   input wire step_down,
   output reg [13:0] pitch
);
   reg [23:0] gap;
   wire fast = (gap < FAST_CYCLES);
   wire [13:0] step = fast ? `PITCH_COARSE : `PITCH_FINE; // RULE5
   wire signed [14:0] up_val = $signed({pitch[13], pitch}) +
      $signed({1'b0, step});
   wire signed [14:0] dn_val = $signed({pitch[13], pitch}) -
      $signed({1'b0, step});
   // Gap counter saturates so a long pause always means a fine step.
   always @(posedge clock) begin
      if (srst || step_up || step_down) begin
         gap <= 24'hFFFFFF;
         if (step_up || step_down)
            gap <= 24'h000000;
      end else if (gap != 24'hFFFFFF) begin
         gap <= gap + 24'h000001;
      end
   end
   // Clamp to the allowed span rather than wrapping.
   always @(posedge clock) begin
      if (srst) begin
         pitch <= 14'h0000;
      end else if (step_up && !step_down) begin
         if (up_val > $signed({1'b0, `PITCH_MAX})) // RULE4
            pitch <= `PITCH_MAX;
         else
            pitch <= up_val[13:0];
      end else if (step_down && !step_up) begin
         if (dn_val < $signed({1'b1, `PITCH_MIN})) // RULE4
            pitch <= `PITCH_MIN;
         else
            pitch <= dn_val[13:0];
      end
   end
endmodule // pitch_knob

// File: all_press.v
// Detects a single or a quick double press of one all-channel button.
`timescale 1ns/1ps
`include "rmsc_consts.vh"
module all_press #(
   parameter WINDOW_CYCLES = `DOUBLE_NS / `CLK_NS
) (
   input wire clock,
   input wire srst,
   input wire press,
   input wire double_style,
   output wire fire
);
   reg [27:0] timer;
   reg armed;
   // First press arms a window; a second press inside it fires.
   assign fire = press && (!double_style || armed); // RULE13
   always @(posedge clock) begin
      if (srst) begin
         armed <= 1'b0;
         timer <= 28'h0000000;
      end else if (press) begin
         armed <= !armed && double_style;
         timer <= WINDOW_CYCLES[27:0];
      end else if (timer != 28'h0000000) begin
         timer <= timer - 28'h0000001;
      end else begin
         armed <= 1'b0;
      end
   end
endmodule // all_press

// File: remote_monitor_speed_control.v
// Top of the remote unit: rehearse, speed reference and monitor selection.
// What this block does
// RULE1 - Rehearse button toggles rehearse mode on each press.
// RULE2 - Rehearse punch-in switches armed channels to input, no real record.
// RULE3 - In rehearse, record and armed indicators keep flashing.
// RULE4 - Variable speed pitch spans minus fifty to plus fifty percent.
// RULE5 - Fast knob turns take large steps, slow ones 0.01 percent.
// RULE6 - Pitch percent view shows deviation from chosen speed.
// RULE7 - Fixed position follows transport speed on crystal reference.
// RULE8 - Outside position tracks external reference, nominal 9,600 kHz.
// RULE9 - External reference rules only when selected and gate is low.
// RULE10 - Variable position takes speed from the pitch knob alone.
// RULE11 - Individual mode takes each monitor from its own selector.
// RULE12 - All buttons force every channel to one monitor source.
// RULE13 - Style switch picks single press or quick double press.
// RULE14 - Individual input position routes the channel's own input.
// RULE15 - Sync position routes record-head playback only while safe.
// RULE16 - Playback position routes reproduce head only while safe.
// RULE17 - Indicators yellow input, green sync while safe, orange playback.
// RULE18 - The remote holds its own search cue points.
// RULE19 - After rehearse punch-in, monitors return to selected source; an armed channel set to sync or playback stays on input until disarmed.
`timescale 1ns/1ps
`include "rmsc_consts.vh"
module remote_monitor_speed_control #(
   parameter CHANNELS = 8,
   parameter CUE_POINTS = 3,
   parameter CUE_WIDTH = 24,
   parameter FLASH_CYCLES = 62500000,
   parameter FAST_CYCLES = `FAST_GAP_NS / `CLK_NS,
   parameter WINDOW_CYCLES = `DOUBLE_NS / `CLK_NS
) (
   input wire clock,
   input wire srst,
   input wire rehearse_button,
   input wire record_button,
   input wire stop_button,
   input wire knob_up,
   input wire knob_down,
   input wire display_key,
   input wire [1:0] speed_selector,
   input wire speed_gate_n,
   input wire ext_ref,
   input wire individual_button,
   input wire all_input_button,
   input wire all_sync_button,
   input wire all_play_button,
   input wire all_press_style_switch,
   input wire [CHANNELS-1:0] ready,
   input wire [2*CHANNELS-1:0] selector,
   input wire cue_set,
   input wire [1:0] cue_index,
   input wire [CUE_WIDTH-1:0] tape_time,
   output reg rehearse,
   output reg record_active,
   output reg [CHANNELS-1:0] recording,
   output reg [2*CHANNELS-1:0] monitor_source,
   output reg [CHANNELS-1:0] led_input,
   output reg [CHANNELS-1:0] led_sync,
   output reg [CHANNELS-1:0] playback_head_monitor,
   output reg [CHANNELS-1:0] led_armed,
   output reg led_record,
   output reg [1:0] capstan_ref,
   output reg ext_ref_out,
   output reg [13:0] capstan_pitch,
   output reg pitch_percent_view,
   output reg [13:0] display_pitch,
   output reg [CUE_WIDTH-1:0] cue_value
);
   // Every pin input except srst and the cue inputs passes two flops; stage one is read by stage two only.
   localparam NIN = 15 + 3 * CHANNELS;
   // Listed from the top bit down; the taps below count up from bit 0,
   // so a change here must be mirrored in every index that follows.
   wire [NIN-1:0] raw = {
      rehearse_button,
      record_button,
      stop_button,
      knob_up,
      knob_down,
      display_key,
      speed_selector,
      speed_gate_n,
      ext_ref,
      individual_button,
      all_input_button,
      all_sync_button,
      all_play_button,
      all_press_style_switch,
      ready,
      selector
   };
   reg [NIN-1:0] sync1;
   reg [NIN-1:0] sync2;
   reg [NIN-1:0] last;
   always @(posedge clock) begin
      if (srst) begin
         sync1 <= {NIN{1'b0}};
         sync2 <= {NIN{1'b0}};
         last <= {NIN{1'b0}};
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         last <= sync2;
      end
   end
   wire [NIN-1:0] rise = sync2 & ~last;
   wire [2*CHANNELS-1:0] s_sel = sync2[2*CHANNELS-1:0];
   wire [CHANNELS-1:0] s_ready = sync2[3*CHANNELS-1:2*CHANNELS];
   localparam B = 3 * CHANNELS;
   wire s_style = sync2[B];
   wire p_all_play = rise[B+1];
   wire p_all_sync = rise[B+2];
   wire p_all_input = rise[B+3];
   wire p_indiv = rise[B+4];
   wire s_ext = sync2[B+5];
   wire s_gate_n = sync2[B+6];
   wire [1:0] s_speed = sync2[B+8:B+7];
   wire p_display = rise[B+9];
   wire p_down = rise[B+10];
   wire p_up = rise[B+11];
   wire p_stop = rise[B+12];
   wire p_record = rise[B+13];
   wire p_rehearse = rise[B+14];

   // Rehearse toggle and punch-in state.
   always @(posedge clock) begin
      if (srst) begin
         rehearse <= 1'b0;
         record_active <= 1'b0;
      end else begin
         if (p_rehearse)
            rehearse <= !rehearse; // RULE1
         if (p_stop)
            record_active <= 1'b0; // RULE19
         else if (p_record)
            record_active <= 1'b1;
      end
   end

   // Real recording happens only outside rehearse.
   always @(posedge clock) begin
      if (srst)
         recording <= {CHANNELS{1'b0}};
      else if (!record_active || rehearse)
         recording <= {CHANNELS{1'b0}}; // RULE2
      else
         recording <= s_ready;
   end

   // All-channel selection; individual mode cancels it.
   wire fire_input;
   wire fire_sync;
   wire fire_play;
   // Each button has its own detector, so half of a double press on one
   // button never counts toward another button.
   all_press #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_all_input (
      .clock(clock),
      .srst(srst),
      .press(p_all_input),
      .double_style(s_style),
      .fire(fire_input)
   );
   all_press #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_all_sync (
      .clock(clock),
      .srst(srst),
      .press(p_all_sync),
      .double_style(s_style),
      .fire(fire_sync)
   );
   all_press #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_all_play (
      .clock(clock),
      .srst(srst),
      .press(p_all_play),
      .double_style(s_style),
      .fire(fire_play)
   );
   reg all_mode;
   reg [1:0] all_source;
   always @(posedge clock) begin
      if (srst) begin
         all_mode <= 1'b0;
         all_source <= `MON_INPUT;
      end else if (p_indiv) begin
         all_mode <= 1'b0; // RULE11
      end else if (fire_input) begin
         all_mode <= 1'b1; // RULE12
         all_source <= `MON_INPUT;
      end else if (fire_sync) begin
         all_mode <= 1'b1;
         all_source <= `MON_SYNC;
      end else if (fire_play) begin
         all_mode <= 1'b1;
         all_source <= `MON_PLAY;
      end
   end

   // Flash timer shared by the armed and record lamps.
   reg [25:0] flash_count;
   reg flash;
   always @(posedge clock) begin
      if (srst) begin
         flash_count <= 26'h0000000;
         flash <= 1'b0;
      end else if (flash_count >= FLASH_CYCLES - 1) begin
         flash_count <= 26'h0000000;
         flash <= !flash;
      end else begin
         flash_count <= flash_count + 26'h0000001;
      end
   end

   // Per-channel monitor routing and lamps.
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
         wire [1:0] pos = s_sel[2*ch+1:2*ch];
         wire [1:0] want = all_mode ? all_source : pos;
         // A punch-in puts an armed channel on input; it is released
         // as soon as the punch ends; a sync or playback selection comes back only once the channel is disarmed.
         wire live = s_ready[ch] && record_active; // RULE2 RULE19
         reg [1:0] src;
         always @* begin
            src = want;
            if (live)
               src = `MON_INPUT; // RULE2
            else if (want == `MON_INPUT)
               src = `MON_INPUT; // RULE14
            else if (want == `MON_SYNC && !s_ready[ch])
               src = `MON_SYNC; // RULE15
            else if (want == `MON_PLAY && !s_ready[ch])
               src = `MON_PLAY; // RULE16
            else
               src = `MON_INPUT;
         end
         always @(posedge clock) begin
            if (srst) begin
               monitor_source[2*ch+1:2*ch] <= `MON_INPUT;
               led_input[ch] <= 1'b0;
               led_sync[ch] <= 1'b0;
               playback_head_monitor[ch] <= 1'b0;
               led_armed[ch] <= 1'b0;
            end else begin
               monitor_source[2*ch+1:2*ch] <= src; // RULE11 RULE12
               led_input[ch] <= (src == `MON_INPUT); // RULE17
               led_sync[ch] <= (src == `MON_SYNC); // RULE17
               playback_head_monitor[ch] <= (src == `MON_PLAY); // RULE17
               if (!s_ready[ch])
                  led_armed[ch] <= 1'b0;
               else if (record_active && !rehearse)
                  led_armed[ch] <= 1'b1;
               else
                  led_armed[ch] <= flash; // RULE3
            end
         end
      end
   endgenerate

   // Record lamp steady only in a real recording.
   always @(posedge clock) begin
      if (srst)
         led_record <= 1'b0;
      else if (record_active && !rehearse)
         led_record <= 1'b1;
      else if (rehearse && (|s_ready))
         led_record <= flash; // RULE3
      else
         led_record <= 1'b0;
   end

   // Knob accumulator feeds the variable speed path.
   wire [13:0] knob_pitch;
   pitch_knob #(.FAST_CYCLES(FAST_CYCLES)) u_knob (
      .clock(clock),
      .srst(srst),
      .step_up(p_up),
      .step_down(p_down),
      .pitch(knob_pitch)
   );

   // Capstan reference. An unused selector code falls back to crystal,
   // the safest source if the switch is between positions.
   always @(posedge clock) begin
      if (srst) begin
         capstan_ref <= `SPD_FIX;
         capstan_pitch <= 14'h0000;
         ext_ref_out <= 1'b0;
      end else begin
         case (s_speed)
            `SPD_EXT: begin
               if (!s_gate_n) begin
                  capstan_ref <= `SPD_EXT; // RULE8 RULE9
                  ext_ref_out <= s_ext; // RULE8
               end else begin
                  capstan_ref <= `SPD_FIX; // RULE9
                  ext_ref_out <= 1'b0;
               end
               capstan_pitch <= 14'h0000;
            end
            `SPD_VARI: begin
               capstan_ref <= `SPD_VARI;
               capstan_pitch <= knob_pitch; // RULE10 RULE4
               ext_ref_out <= 1'b0;
            end
            default: begin
               capstan_ref <= `SPD_FIX; // RULE7
               capstan_pitch <= 14'h0000;
               ext_ref_out <= 1'b0;
            end
         endcase
      end
   end

   // Display key cycles three views; the third is the pitch percent view.
   reg [1:0] view;
   always @(posedge clock) begin
      if (srst) begin
         view <= 2'h0;
         pitch_percent_view <= 1'b0;
         display_pitch <= 14'h0000;
      end else begin
         if (p_display)
            view <= (view == 2'h2) ? 2'h0 : view + 2'h1;
         pitch_percent_view <= (view == 2'h2); // RULE6
         display_pitch <= capstan_pitch; // RULE6
      end
   end

   // Remote-owned cue store, apart from the transport's.
   reg [CUE_WIDTH-1:0] cue_mem [0:CUE_POINTS-1];
   integer i;
   always @(posedge clock) begin
      if (srst) begin
         for (i = 0; i < CUE_POINTS; i = i + 1)
            cue_mem[i] <= {CUE_WIDTH{1'b0}};
         cue_value <= {CUE_WIDTH{1'b0}};
      end else begin
         if (cue_set && cue_index < CUE_POINTS)
            cue_mem[cue_index] <= tape_time; // RULE18
         if (cue_index < CUE_POINTS)
            cue_value <= cue_mem[cue_index]; // RULE18
         else
            cue_value <= {CUE_WIDTH{1'b0}};
      end
   end
endmodule // remote_monitor_speed_control

// File: rmsc_props.sv
// Concurrent checks on the remote monitor and speed control ports.
`timescale 1ns/1ps
`include "rmsc_consts.vh"
module rmsc_props #(
   parameter CHANNELS = 8,
   parameter FLASH_CYCLES = 4
) (
   input wire clock,
   input wire srst,
   input wire rehearse_button,
   input wire record_button,
   input wire display_key,
   input wire [1:0] speed_selector,
   input wire speed_gate_n,
   input wire rehearse,
   input wire record_active,
   input wire [CHANNELS-1:0] recording,
   input wire [CHANNELS-1:0] led_input,
   input wire [CHANNELS-1:0] led_sync,
   input wire [CHANNELS-1:0] playback_head_monitor,
   input wire led_record,
   input wire [1:0] capstan_ref,
   input wire [13:0] capstan_pitch,
   input wire pitch_percent_view
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   int quiet;
   reg last_led;
   // Cycles without a record lamp edge while a rehearse punch is held.
   always @(posedge clock) begin
      last_led <= led_record;
      if (srst || !rehearse || !record_active || led_record != last_led)
         quiet <= 0;
      else
         quiet <= quiet + 1;
   end
   toggle_cause_a: assert property ($changed(rehearse) |->
      $past(rehearse_button, 2) || $past(rehearse_button, 3)
      || $past(rehearse_button, 4)) else $error("rehearse moved alone");
   punch_cause_a: assert property ($rose(record_active) |->
      $past(record_button, 2) || $past(record_button, 3)
      || $past(record_button, 4)) else $error("record started alone");
   no_record_a: assert property (rehearse && $past(rehearse, 2)
      |-> recording == '0) else $error("real record in rehearse");
   lamp_flash_a: assert property (quiet <= 2 * FLASH_CYCLES + 4)
      else $error("record lamp went steady");
   pitch_span_a: assert property (!(capstan_pitch > `PITCH_MAX
      && capstan_pitch < `PITCH_MIN)) else $error("pitch out of span");
   view_cause_a: assert property ($changed(pitch_percent_view) |->
      $past(display_key, 2) || $past(display_key, 3)
      || $past(display_key, 4)) else $error("view moved alone");
   ext_gate_a: assert property ((speed_selector == `SPD_EXT
      && !speed_gate_n) [*6] |-> capstan_ref == `SPD_EXT)
      else $error("external reference not taken");
   gate_high_a: assert property ((speed_selector == `SPD_EXT
      && speed_gate_n) [*6] |-> capstan_ref == `SPD_FIX)
      else $error("external reference taken while gated");
   vari_ref_a: assert property ((speed_selector == `SPD_VARI) [*6]
      |-> capstan_ref == `SPD_VARI) else $error("variable not taken");
   one_lamp_a: assert property (!$past(srst) |-> $onehot(
      {led_input[0], led_sync[0], playback_head_monitor[0]}))
      else $error("monitor lamps not one hot");
endmodule // rmsc_props
bind remote_monitor_speed_control rmsc_props #(.CHANNELS(CHANNELS),
   .FLASH_CYCLES(FLASH_CYCLES)) u_props (.clock(clock), .srst(srst),
   .rehearse_button(rehearse_button), .record_button(record_button),
   .display_key(display_key), .speed_selector(speed_selector),
   .speed_gate_n(speed_gate_n), .rehearse(rehearse),
   .record_active(record_active), .recording(recording),
   .led_input(led_input), .led_sync(led_sync),
   .playback_head_monitor(playback_head_monitor), .led_record(led_record),
   .capstan_ref(capstan_ref), .capstan_pitch(capstan_pitch),
   .pitch_percent_view(pitch_percent_view));

// File: transport_model.sv
// Transport side model: external speed reference and its gate line.
`timescale 1ns/1ps
module transport_model (
   input wire clock,
   input wire gate_req,
   output logic ext_ref,
   output logic speed_gate_n
);
   // A scaled stand-in for the nominal reference; a slow clock would
   // stretch the run for nothing.
   initial ext_ref = 1'b0;
   always @(posedge clock) ext_ref <= #1 ~ext_ref;
   // The gate is driven low only while the bench asks for control.
   assign speed_gate_n = ~gate_req;
endmodule // transport_model

// File: tb_top.sv
// Self-checking bench for the remote monitor and speed control block.
`timescale 1ns/1ps
`include "rmsc_consts.vh"
module tb_top;
   logic clock = 0, srst = 1, gate_req = 0, all_press_style_switch = 0;
   logic rehearse_button = 0, record_button = 0, stop_button = 0;
   logic knob_up = 0, knob_down = 0, display_key = 0, individual_button = 0;
   logic all_input_button = 0, all_sync_button = 0, all_play_button = 0;
   logic [1:0] speed_selector = 0;
   logic [7:0] ready = 0;
   logic [15:0] selector = 0;
   logic cue_set = 0;
   logic [1:0] cue_index = 0;
   logic [23:0] tape_time = 0;
   wire [23:0] cue_value;
   wire speed_gate_n, ext_ref, rehearse, record_active, led_record;
   wire ext_ref_out, pitch_percent_view;
   wire [7:0] recording, led_input, led_sync, playback_head_monitor;
   wire [7:0] led_armed;
   wire [15:0] monitor_source;
   wire [1:0] capstan_ref;
   wire [13:0] capstan_pitch, display_pitch;
   int err_count = 0, samples_checked = 0, cyc = 0;
   // Short counts keep flash, velocity and double press quick to reach.
   remote_monitor_speed_control #(.FLASH_CYCLES(4), .FAST_CYCLES(8),
      .WINDOW_CYCLES(10)) u_dut (.clock, .srst, .rehearse_button,
      .record_button, .stop_button, .knob_up, .knob_down, .display_key,
      .speed_selector, .speed_gate_n, .ext_ref, .individual_button,
      .all_input_button, .all_sync_button, .all_play_button,
      .all_press_style_switch, .ready, .selector, .cue_set, .cue_index,
      .tape_time, .rehearse, .record_active,
      .recording, .monitor_source, .led_input, .led_sync,
      .playback_head_monitor, .led_armed, .led_record, .capstan_ref,
      .ext_ref_out, .capstan_pitch, .pitch_percent_view, .display_pitch,
      .cue_value);
   transport_model u_far (.clock, .gate_req, .ext_ref, .speed_gate_n);
   always #2 clock = ~clock;
   // A hang counts as a mismatch and ends the run.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         stop_test;
      end
   end
   task wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task setb(input int b, input logic v);
      case (b)
         0: rehearse_button = v;
         1: record_button = v;
         2: stop_button = v;
         3: individual_button = v;
         4: all_input_button = v;
         5: all_sync_button = v;
         6: all_play_button = v;
         7: display_key = v;
         8: knob_up = v;
         default: knob_down = v;
      endcase
   endtask
   // Pin high for two edges, then low for n edges.
   task press(input int b, input int n);
      setb(b, 1);
      wt(2);
      setb(b, 0);
      wt(n);
   endtask
   task t_speed;
      logic seen;
      gate_req = 1;
      wt(10);
      chk(capstan_ref, `SPD_FIX);
      speed_selector = `SPD_EXT;
      wt(10);
      chk(capstan_ref, `SPD_EXT);
      seen = ext_ref_out;
      wt(1);
      chk(ext_ref_out ^ seen, 1);
      gate_req = 0;
      wt(10);
      chk(capstan_ref, `SPD_FIX);
      chk(ext_ref_out, 0);
      speed_selector = `SPD_VARI;
      wt(10);
      chk(capstan_ref, `SPD_VARI);
      $display("speed test done");
   endtask
   task t_pitch;
      wt(20);
      press(8, 12);
      chk(capstan_pitch, `PITCH_FINE);
      repeat (60) press(8, 2);
      chk(capstan_pitch, `PITCH_MAX);
      repeat (120) press(9, 2);
      wt(8);
      chk(capstan_pitch, `PITCH_MIN);
      press(7, 8);
      press(7, 8);
      chk(pitch_percent_view, 1);
      chk(display_pitch, `PITCH_MIN);
      press(7, 8);
      chk(pitch_percent_view, 0);
      $display("pitch test done");
   endtask
   task t_monitor;
      selector = 16'h0019;
      press(3, 8);
      chk(led_sync[0], 1);
      chk(playback_head_monitor[1], 1);
      chk(led_input[3], 1);
      ready = 8'h01;
      wt(8);
      chk(led_input[0], 1);
      ready = 8'h00;
      press(6, 8);
      chk(playback_head_monitor, 8'hFF);
      all_press_style_switch = 1;
      press(4, 20);
      chk(playback_head_monitor, 8'hFF);
      press(4, 2);
      press(4, 8);
      chk(led_input, 8'hFF);
      press(5, 2);
      press(5, 8);
      chk(led_sync, 8'hFF);
      press(3, 8);
      chk(monitor_source, 16'h0019);
      $display("monitor test done");
   endtask
   task t_rehearse;
      logic lamp;
      logic armed;
      selector = 16'h0008;
      ready = 8'h01;
      press(0, 8);
      chk(rehearse, 1);
      press(1, 30);
      chk(recording, 8'h00);
      chk(monitor_source, 16'h0008);
      lamp = led_record;
      armed = led_armed[0];
      wt(4);
      chk(led_record ^ lamp, 1);
      chk(led_armed[0] ^ armed, 1);
      press(2, 8);
      chk(monitor_source[3:2], `MON_PLAY);
      press(0, 8);
      chk(rehearse, 0);
      press(1, 8);
      chk(recording, 8'h01);
      chk(led_record, 1);
      press(2, 8);
      $display("rehearse test done");
   endtask
   // Cue points written and read back; an index past the store reads 0.
   task t_cue;
      cue_index = 2'h1;
      tape_time = 24'h00ABCD;
      cue_set = 1;
      wt(1);
      cue_index = 2'h2;
      tape_time = 24'h123456;
      wt(1);
      cue_set = 0;
      cue_index = 2'h1;
      wt(2);
      chk(cue_value, 24'h00ABCD);
      cue_index = 2'h2;
      wt(2);
      chk(cue_value, 24'h123456);
      cue_index = 2'h3;
      cue_set = 1;
      wt(1);
      cue_set = 0;
      wt(2);
      chk(cue_value, 24'h000000);
      cue_index = 2'h1;
      wt(2);
      chk(cue_value, 24'h00ABCD);
      $display("cue test done");
   endtask
   task stop_test;
      $display("compared %0d mismatched %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset for four cycles, then the scenarios in turn.
   initial begin
      wt(4);
      srst = 0;
      t_speed;
      t_pitch;
      t_monitor;
      t_rehearse;
      t_cue;
      stop_test;
   end
endmodule // tb_top
